// ==== rtl/ieh_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RULE1] AXI DECERR drops the request and pulses the decode-error strobe.
// [RULE2] Non-posted request with DECERR gets an Unsupported Request completion.
// [RULE3] AXI SLVERR drops the request and pulses the slave-error strobe.
// [RULE4] Non-posted request with SLVERR gets a Completer Abort completion.
// [RULE5] Requester keeps within payload, read-request sizes and 4 KB pages.
// [RULE6] Oversized or page-crossing requests are processed like valid ones, unchecked, up to one 256-beat AXI burst.
// [RULE7] No malformed-TLP completion is ever sent for size or page violations.
// [RULE8] Read data splits into completions of at most MPS, on MPS-aligned address boundaries.
// [RULE9] Poisoned memory request is discarded whole and pulses the poison strobe.
// [RULE10] Zero-length read gets a Successful Completion.
// [RULE11] Zero-length write does nothing and issues no AXI write.
// [RULE12] Posted write with DECERR only pulses decode-error strobe, no completion.
// [RULE13] Posted write with SLVERR only pulses slave-error strobe, no completion.
// [RULE14] Poisoned request also sets the sticky poisoned-request status bit.
// [RULE15] Each error strobe is a one-cycle pulse, once per failing request.
module ieh_master #(
    parameter int MPS_DW = ieh_pkg::MPS_DW_DEF
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic                   req_valid,
    input  wire ieh_pkg::ieh_req_t      req,
    output var  logic                   req_ready,
    input  wire logic                   pay_valid,
    input  wire logic [31:0]            pay_data,
    output var  logic                   pay_ready,
    output var  logic                   cpl_valid,
    output var  ieh_pkg::ieh_cpl_t      cpl,
    input  wire logic                   cpl_ready,
    output var  logic                   m_axi_arvalid,
    output var  ieh_pkg::ieh_axi_addr_t m_axi_ar,
    input  wire logic                   m_axi_arready,
    input  wire logic                   m_axi_rvalid,
    input  wire logic [31:0]            m_axi_rdata,
    input  wire logic [1:0]             m_axi_rresp,
    input  wire logic                   m_axi_rlast,
    output var  logic                   m_axi_rready,
    output var  logic                   m_axi_awvalid,
    output var  ieh_pkg::ieh_axi_addr_t m_axi_aw,
    input  wire logic                   m_axi_awready,
    output var  logic                   m_axi_wvalid,
    output var  ieh_pkg::ieh_axi_w_t    m_axi_w,
    input  wire logic                   m_axi_wready,
    input  wire logic                   m_axi_bvalid,
    input  wire logic [1:0]             m_axi_bresp,
    output var  logic                   m_axi_bready,
    output var  logic                   master_decode_error_irq,
    output var  logic                   master_slave_error_irq,
    output var  logic                   master_poisoned_request_irq,
    output var  logic                   poisoned_status,
    input  wire logic                   poisoned_status_clr
);
    import ieh_pkg::*;
    localparam int MPS_LOG = $clog2(MPS_DW);
    if (MPS_DW < 2 || MPS_DW > MAX_BEATS || (1 << MPS_LOG) != MPS_DW) begin : g_bad_mps
        $error("MPS_DW must be a power of two from 2 to 256");
    end
    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // State
    ieh_state_t         state;
    ieh_req_t           cur;
    logic [CNT_W-1:0]   rem;
    logic [CNT_W-1:0]   drain_left;
    logic [CNT_W-1:0]   chunk_left;
    logic [ADDR_W-3:0]  cur_dw;
    logic               rd_err;
    logic               last_cpl;
    logic               first_beat;
    ////////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic logic is_zero_len(input ieh_req_t r);
        return r.len_dw == ZERO_LEN && r.first_be == ZERO_BE && r.last_be == ZERO_BE;
    endfunction : is_zero_len
    wire              req_take   = req_valid && req_ready;
    wire              req_zero   = is_zero_len(req);
    wire [CNT_W-1:0]  req_dws    = (req.len_dw == 10'h000) ? 11'h400 : {1'b0, req.len_dw};
    // Bursts cap at 256 beats; longer requests lose data
    wire [CNT_W-1:0]  axi_beats  = (req_dws > 11'h100) ? 11'h100 : req_dws; // [RULE6]
    wire [7:0]        axi_len    = 8'(axi_beats - 11'h001);
    wire              r_take     = m_axi_rvalid && m_axi_rready;
    wire              r_err      = m_axi_rresp[1];
    wire [2:0]        err_status = (m_axi_rresp == RESP_DECERR) ? CPL_UR : CPL_CA; // [RULE2] [RULE4]
    wire              cpl_take   = cpl_valid && cpl_ready;
    wire              pay_take   = pay_valid && pay_ready;
    wire              w_take     = m_axi_wvalid && m_axi_wready;
    wire              b_take     = m_axi_bvalid && m_axi_bready;
    wire              new_chunk  = chunk_left == '0;
    wire [CNT_W-1:0]  room       = CNT_W'(MPS_DW) - CNT_W'(cur_dw[MPS_LOG-1:0]);
    wire [CNT_W-1:0]  chunk_len  = (rem < room) ? rem : room; // [RULE8]
    wire              last_beat  = rem == 11'h001;
    wire              irq_dec_ev = (r_take && ce && r_err && !rd_err && m_axi_rresp == RESP_DECERR)
                                || (b_take && m_axi_bresp == RESP_DECERR);
    wire              irq_slv_ev = (r_take && ce && r_err && !rd_err && m_axi_rresp == RESP_SLVERR)
                                || (b_take && m_axi_bresp == RESP_SLVERR);
    wire              poison_ev  = req_take && req.poisoned;
    wire              stat_keep  = poisoned_status && !poisoned_status_clr;
    ////////////////////////////////////////////////////////////////////////////
    // Error strobes and sticky status
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            master_decode_error_irq     <= 1'b0;
            master_slave_error_irq      <= 1'b0;
            master_poisoned_request_irq <= 1'b0;
            poisoned_status             <= 1'b0;
        end else if (ce) begin
            master_decode_error_irq     <= irq_dec_ev; // [RULE1] [RULE12] [RULE15]
            master_slave_error_irq      <= irq_slv_ev; // [RULE3] [RULE13] [RULE15]
            master_poisoned_request_irq <= poison_ev;  // [RULE9] [RULE15]
            poisoned_status             <= poison_ev || stat_keep; // [RULE14]
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Request sequencer
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state         <= ST_IDLE;
            cur           <= '0;
            rem           <= '0;
            drain_left    <= '0;
            chunk_left    <= '0;
            cur_dw        <= '0;
            rd_err        <= 1'b0;
            last_cpl      <= 1'b0;
            first_beat    <= 1'b0;
            req_ready     <= 1'b1;
            pay_ready     <= 1'b0;
            cpl_valid     <= 1'b0;
            cpl           <= '0;
            m_axi_arvalid <= 1'b0;
            m_axi_ar      <= '{addr: '0, len: AXI_LEN_RST};
            m_axi_rready  <= 1'b0;
            m_axi_awvalid <= 1'b0;
            m_axi_aw      <= '{addr: '0, len: AXI_LEN_RST};
            m_axi_wvalid  <= 1'b0;
            m_axi_w       <= '0;
            m_axi_bready  <= 1'b0;
        end else if (ce) begin
            case (state)
                ST_IDLE: begin
                    if (req_take) begin
                        req_ready  <= 1'b0;
                        cur        <= req;
                        cur_dw     <= req.addr[ADDR_W-1:2];
                        rd_err     <= 1'b0;
                        chunk_left <= '0;
                        first_beat <= 1'b1;
                        if (req.poisoned) begin
                            if (req.is_write) begin // [RULE9]
                                rem       <= req_dws;
                                pay_ready <= 1'b1;
                                state     <= ST_DRAIN;
                            end else begin
                                req_ready <= 1'b1;
                            end
                        end else if (req_zero && req.is_write) begin
                            rem       <= 11'h001; // [RULE11]
                            pay_ready <= 1'b1;
                            state     <= ST_DRAIN;
                        end else if (req_zero) begin
                            cpl       <= '{sop: 1'b1, eop: 1'b1, status: CPL_SC, len_dw: ZERO_LEN,
                                           byte_count: 13'h0001, requester_id: req.requester_id,
                                           tag: req.tag, data: '0}; // [RULE10]
                            cpl_valid <= 1'b1;
                            last_cpl  <= 1'b1;
                            state     <= ST_CPL;
                        end else if (req.is_write) begin
                            rem           <= axi_beats;
                            drain_left    <= req_dws - axi_beats;
                            m_axi_aw      <= '{addr: {req.addr[ADDR_W-1:2], 2'b00}, len: axi_len};
                            m_axi_awvalid <= 1'b1;
                            state         <= ST_AW;
                        end else begin
                            rem           <= axi_beats;
                            m_axi_ar      <= '{addr: {req.addr[ADDR_W-1:2], 2'b00}, len: axi_len};
                            m_axi_arvalid <= 1'b1;
                            state         <= ST_AR;
                        end
                    end
                end
                ST_AR: begin
                    if (m_axi_arready) begin
                        m_axi_arvalid <= 1'b0;
                        m_axi_rready  <= 1'b1;
                        state         <= ST_RD;
                    end
                end
                ST_RD: begin
                    if (r_take) begin
                        rem    <= rem - 11'h001;
                        cur_dw <= cur_dw + 1'b1;
                        if (r_err && !rd_err) begin
                            rd_err    <= 1'b1;
                            cpl       <= '{sop: 1'b1, eop: 1'b1, status: err_status, len_dw: '0,
                                           byte_count: '0, requester_id: cur.requester_id,
                                           tag: cur.tag, data: '0}; // [RULE2] [RULE4]
                            cpl_valid    <= 1'b1;
                            last_cpl     <= m_axi_rlast || last_beat;
                            m_axi_rready <= 1'b0;
                            state        <= ST_CPL;
                        end else if (rd_err) begin
                            if (m_axi_rlast || last_beat) begin
                                m_axi_rready <= 1'b0;
                                req_ready    <= 1'b1;
                                state        <= ST_IDLE;
                            end
                        end else begin
                            chunk_left   <= (new_chunk ? chunk_len : chunk_left) - 11'h001;
                            cpl          <= '{sop: new_chunk,
                                              eop: (new_chunk ? chunk_len : chunk_left) == 11'h001,
                                              status: CPL_SC, len_dw: 10'(chunk_len),
                                              byte_count: {rem, 2'b00},
                                              requester_id: cur.requester_id,
                                              tag: cur.tag, data: m_axi_rdata}; // [RULE8]
                            cpl_valid    <= 1'b1;
                            last_cpl     <= m_axi_rlast || last_beat;
                            m_axi_rready <= 1'b0;
                            state        <= ST_CPL;
                        end
                    end
                end
                ST_CPL: begin
                    if (cpl_take) begin
                        cpl_valid <= 1'b0;
                        if (last_cpl) begin
                            req_ready <= 1'b1;
                            state     <= ST_IDLE;
                        end else begin
                            m_axi_rready <= 1'b1;
                            state        <= ST_RD;
                        end
                    end
                end
                ST_AW: begin
                    if (m_axi_awready) begin
                        m_axi_awvalid <= 1'b0;
                        pay_ready     <= 1'b1;
                        state         <= ST_WD;
                    end
                end
                ST_WD: begin
                    if (pay_take) begin
                        pay_ready    <= 1'b0;
                        first_beat   <= 1'b0;
                        m_axi_wvalid <= 1'b1;
                        m_axi_w      <= '{data: pay_data,
                                          strb: first_beat ? cur.first_be
                                              : (last_beat ? cur.last_be : 4'hF),
                                          last: last_beat};
                    end else if (w_take) begin
                        m_axi_wvalid <= 1'b0;
                        rem          <= rem - 11'h001;
                        if (m_axi_w.last) begin
                            m_axi_bready <= 1'b1;
                            state        <= ST_WB;
                        end else begin
                            pay_ready <= 1'b1;
                        end
                    end
                end
                ST_WB: begin
                    if (b_take) begin
                        m_axi_bready <= 1'b0; // [RULE12] [RULE13]
                        if (drain_left != '0) begin
                            rem       <= drain_left;
                            pay_ready <= 1'b1;
                            state     <= ST_DRAIN;
                        end else begin
                            req_ready <= 1'b1;
                            state     <= ST_IDLE;
                        end
                    end
                end
                ST_DRAIN: begin
                    if (pay_take) begin
                        rem <= rem - 11'h001;
                        if (last_beat) begin
                            pay_ready <= 1'b0;
                            req_ready <= 1'b1;
                            state     <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    req_ready <= 1'b1;
                    state     <= ST_IDLE;
                end
            endcase
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_dec_irq;
        (ce && b_take && m_axi_bresp == RESP_DECERR) |=> master_decode_error_irq;
    endproperty
    a_dec_irq: assert property (p_dec_irq) else $error("decode error strobe missing"); // [RULE12]
    property p_slv_irq;
        (ce && r_take && !rd_err && m_axi_rresp == RESP_SLVERR) |=> master_slave_error_irq;
    endproperty
    a_slv_irq: assert property (p_slv_irq) else $error("slave error strobe missing"); // [RULE3]
    property p_ur_cpl;
        (ce && r_take && !rd_err && m_axi_rresp == RESP_DECERR)
            |=> cpl_valid && cpl.status == CPL_UR && cpl.eop;
    endproperty
    a_ur_cpl: assert property (p_ur_cpl) else $error("no UR completion after DECERR"); // [RULE2]
    property p_ca_cpl;
        (ce && r_take && !rd_err && m_axi_rresp == RESP_SLVERR)
            |=> cpl_valid && cpl.status == CPL_CA && master_slave_error_irq;
    endproperty
    a_ca_cpl: assert property (p_ca_cpl) else $error("no CA completion after SLVERR"); // [RULE4]
    property p_poison;
        (ce && poison_ev) |=> master_poisoned_request_irq && poisoned_status
            && !m_axi_arvalid && !m_axi_awvalid;
    endproperty
    a_poison: assert property (p_poison) else $error("poisoned request not discarded"); // [RULE9]
    property p_pulse;
        (master_decode_error_irq && ce) ##1 ce |-> !master_decode_error_irq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("decode error strobe too long"); // [RULE15]
    property p_zero_rd;
        (ce && req_take && req_zero && !req.is_write && !req.poisoned)
            |=> cpl_valid && cpl.status == CPL_SC && cpl.sop && cpl.eop && !m_axi_arvalid;
    endproperty
    a_zero_rd: assert property (p_zero_rd) else $error("zero-length read unanswered"); // [RULE10]
    property p_zero_wr;
        (ce && req_take && req_zero && req.is_write) |=> !m_axi_awvalid [*2];
    endproperty
    a_zero_wr: assert property (p_zero_wr) else $error("zero-length write on AXI"); // [RULE11]
    property p_mps;
        (cpl_valid && cpl.sop && cpl.status == CPL_SC) |-> cpl.len_dw <= 10'(MPS_DW);
    endproperty
    a_mps: assert property (p_mps) else $error("completion exceeds payload size"); // [RULE8]
endmodule : ieh_master
`default_nettype wire

// ==== rtl/ieh_pkg.sv ====
`default_nettype none
package ieh_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int CNT_W  = 11;

    // Completion status codes
    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] CPL_CA = 3'h4;

    // AXI response codes
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Zero-length request signature
    localparam logic [9:0] ZERO_LEN = 10'h001;
    localparam logic [3:0] ZERO_BE  = 4'h0;

    // Defaults and reset values
    localparam int         MPS_DW_DEF  = 32;
    localparam int         MAX_BEATS   = 256;
    localparam logic [7:0] AXI_LEN_RST = 8'h00;

    typedef struct packed {
        logic        is_write;
        logic        poisoned;
        logic [31:0] addr;
        logic [9:0]  len_dw;
        logic [3:0]  first_be;
        logic [3:0]  last_be;
        logic [15:0] requester_id;
        logic [7:0]  tag;
    } ieh_req_t;

    typedef struct packed {
        logic        sop;
        logic        eop;
        logic [2:0]  status;
        logic [9:0]  len_dw;
        logic [12:0] byte_count;
        logic [15:0] requester_id;
        logic [7:0]  tag;
        logic [31:0] data;
    } ieh_cpl_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  len;
    } ieh_axi_addr_t;

    typedef struct packed {
        logic [31:0] data;
        logic [3:0]  strb;
        logic        last;
    } ieh_axi_w_t;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_AR    = 8'h02,
        ST_RD    = 8'h04,
        ST_CPL   = 8'h08,
        ST_AW    = 8'h10,
        ST_WD    = 8'h20,
        ST_WB    = 8'h40,
        ST_DRAIN = 8'h80
    } ieh_state_t;
endpackage : ieh_pkg
`default_nettype wire

// ==== verification/ieh_axi_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
module ieh_axi_slave (
    input  wire logic                   clk_sys,
    input  wire logic [1:0]             resp,
    input  wire logic                   m_axi_arvalid,
    input  wire ieh_pkg::ieh_axi_addr_t m_axi_ar,
    output var  logic                   m_axi_arready = 1'h0,
    output var  logic                   m_axi_rvalid = 1'h0,
    output var  logic [31:0]            m_axi_rdata = 32'h0,
    output var  logic [1:0]             m_axi_rresp = 2'h0,
    output var  logic                   m_axi_rlast = 1'h0,
    input  wire logic                   m_axi_rready,
    input  wire logic                   m_axi_awvalid,
    output var  logic                   m_axi_awready = 1'h0,
    input  wire logic                   m_axi_wvalid,
    input  wire ieh_pkg::ieh_axi_w_t    m_axi_w,
    output var  logic                   m_axi_wready = 1'h0,
    output var  logic                   m_axi_bvalid = 1'h0,
    output var  logic [1:0]             m_axi_bresp = 2'h0,
    input  wire logic                   m_axi_bready
);
    import ieh_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Read burst: data is the beat address, inverted once released
    always begin
        @(posedge clk_sys);
        if (m_axi_arvalid) begin
            m_axi_arready <= 1'h1;
            @(posedge clk_sys);
            m_axi_arready <= 1'h0;
            for (int i = 0; i <= m_axi_ar.len; i++) begin
                m_axi_rvalid <= 1'h1;
                m_axi_rdata  <= m_axi_ar.addr + 4 * i;
                m_axi_rresp  <= resp;
                m_axi_rlast  <= (i == m_axi_ar.len);
                do @(posedge clk_sys); while (!m_axi_rready);
            end
            m_axi_rvalid <= 1'h0;
            m_axi_rlast  <= 1'h0;
            m_axi_rdata  <= ~m_axi_rdata;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Write burst: one response after the last beat
    always begin
        @(posedge clk_sys);
        if (m_axi_awvalid) begin
            m_axi_awready <= 1'h1;
            @(posedge clk_sys);
            m_axi_awready <= 1'h0;
            m_axi_wready  <= 1'h1;
            do @(posedge clk_sys); while (!(m_axi_wvalid && m_axi_w.last));
            m_axi_wready <= 1'h0;
            m_axi_bvalid <= 1'h1;
            m_axi_bresp  <= resp;
            do @(posedge clk_sys); while (!m_axi_bready);
            m_axi_bvalid <= 1'h0;
            m_axi_bresp  <= ~resp;
        end
    end
endmodule : ieh_axi_slave
`default_nettype wire

// ==== verification/inbound_master_error_handling_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module inbound_master_error_handling_test;
    import ieh_pkg::*;
    localparam int MPS = 4;
    logic clk_sys = 1'h0, rst_n = 1'h0, ce = 1'h1, req_valid = 1'h0, pay_valid = 1'h0;
    logic cpl_ready = 1'h0, poisoned_status_clr = 1'h0, req_ready, pay_ready, cpl_valid;
    logic [31:0] pay_data = 32'h0, m_axi_rdata;
    logic [1:0] resp = 2'h0, m_axi_rresp, m_axi_bresp;
    ieh_req_t req = '0;
    ieh_cpl_t cpl, cq[$];
    ieh_axi_addr_t m_axi_ar, m_axi_aw, last_ar;
    ieh_axi_w_t m_axi_w, last_w;
    logic m_axi_arvalid, m_axi_arready, m_axi_rvalid, m_axi_rlast, m_axi_rready;
    logic m_axi_awvalid, m_axi_awready, m_axi_wvalid, m_axi_wready, m_axi_bvalid;
    logic m_axi_bready, poisoned_status, master_decode_error_irq, master_slave_error_irq;
    logic master_poisoned_request_irq;
    int mismatches = 0, n_compared = 0, n_de = 0, n_se = 0, n_po = 0, n_aw = 0;
    always #5 clk_sys = ~clk_sys;
    ieh_master #(.MPS_DW(MPS)) DUT (.clk_sys, .rst_n, .ce, .req_valid, .req, .req_ready,
        .pay_valid, .pay_data, .pay_ready, .cpl_valid, .cpl, .cpl_ready, .m_axi_arvalid,
        .m_axi_ar, .m_axi_arready, .m_axi_rvalid, .m_axi_rdata, .m_axi_rresp, .m_axi_rlast,
        .m_axi_rready, .m_axi_awvalid, .m_axi_aw, .m_axi_awready, .m_axi_wvalid, .m_axi_w,
        .m_axi_wready, .m_axi_bvalid, .m_axi_bresp, .m_axi_bready, .master_decode_error_irq,
        .master_slave_error_irq, .master_poisoned_request_irq, .poisoned_status,
        .poisoned_status_clr);
    ieh_axi_slave u_slave (.clk_sys, .resp, .m_axi_arvalid, .m_axi_ar, .m_axi_arready,
        .m_axi_rvalid, .m_axi_rdata, .m_axi_rresp, .m_axi_rlast, .m_axi_rready,
        .m_axi_awvalid, .m_axi_awready, .m_axi_wvalid, .m_axi_w, .m_axi_wready,
        .m_axi_bvalid, .m_axi_bresp, .m_axi_bready);
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (cpl_valid && cpl_ready) cq.push_back(cpl);
        if (m_axi_arvalid && m_axi_arready) last_ar = m_axi_ar;
        if (m_axi_wvalid && m_axi_wready) last_w = m_axi_w;
        n_aw += (m_axi_awvalid && m_axi_awready);
        n_de += (rst_n && master_decode_error_irq);
        n_se += (rst_n && master_slave_error_irq);
        n_po += (rst_n && master_poisoned_request_irq);
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wt(ref logic rdy);
        for (int i = 0; i < 200 && rdy !== 1'h1; i++) @(posedge clk_sys) #1;
        @(posedge clk_sys) #1;
    endtask : wt
    task automatic send(input logic wr, pz, input logic [31:0] a, input logic [9:0] n,
                        input logic [3:0] be);
        req = '{wr, pz, a, n, be, be, 16'h0123, 8'h2A};
        req_valid = 1'h1;
        wt(req_ready);
        req_valid = 1'h0;
        pay_valid = wr;
        for (int k = 0; wr && k < n; k++) begin
            pay_data = a + k;
            wt(pay_ready);
        end
        pay_valid = 1'h0;
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 300 && req_ready !== 1'h1; i++) @(posedge clk_sys) #1;
        repeat (3) @(posedge clk_sys) #1;
    endtask : send
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_err(input logic [1:0] r, input logic [2:0] st);
        int de = n_de, se = n_se, aw = n_aw;
        resp = r;
        cq.delete();
        // Two error beats: the second is dropped, no second strobe
        send(1'h0, 1'h0, 32'h40, 10'h2, 4'hF);
        chk("cpl status", cq[0].status, st);
        send(1'h1, 1'h0, 32'h80, 10'h2, 4'hF);
        chk("w data", last_w.data, 32'h81);
        chk("w last", last_w.last, 1);
        chk("cpl count", cq.size(), 1);
        chk("aw count", n_aw - aw, 1);
        chk("decode irq", n_de - de, 2 * (r == RESP_DECERR));
        chk("slave irq", n_se - se, 2 * (r == RESP_SLVERR));
    endtask : t_err
    task automatic t_poison();
        int po = n_po, aw = n_aw;
        cq.delete();
        send(1'h1, 1'h1, 32'h100, 10'h3, 4'hF);
        send(1'h0, 1'h1, 32'h100, 10'h1, 4'hF);
        chk("poison irq", n_po - po, 2);
        chk("poison axi", n_aw - aw + cq.size(), 0);
        chk("poison status", poisoned_status, 1);
        // Clock enable low must hold the sticky bit despite the clear
        ce = 1'h0;
        poisoned_status_clr = 1'h1;
        @(posedge clk_sys) #1;
        chk("frozen status", poisoned_status, 1);
        ce = 1'h1;
        @(posedge clk_sys) #1;
        poisoned_status_clr = 1'h0;
        @(posedge clk_sys) #1;
        chk("poison clear", poisoned_status, 0);
    endtask : t_poison
    task automatic t_zero();
        int aw = n_aw;
        resp = RESP_DECERR + 2'h1;
        cq.delete();
        send(1'h0, 1'h0, 32'h200, ZERO_LEN, ZERO_BE);
        send(1'h1, 1'h0, 32'h200, ZERO_LEN, ZERO_BE);
        chk("zero cpl", cq.size(), 1);
        chk("zero status", cq[0].status, CPL_SC);
        chk("zero aw", n_aw - aw, 0);
    endtask : t_zero
    task automatic t_split();
        cq.delete();
        // Crosses a 4 KB page on purpose
        send(1'h0, 1'h0, 32'hFF8, 10'h8, 4'hF);
        chk("ar len", last_ar.len, 8'h07);
        chk("beats", cq.size(), 8);
        for (int i = 0; i < 8; i++) begin
            chk("data", cq[i].data, 32'hFF8 + 4 * i);
            chk("sop", cq[i].sop, i == 0 || i == 2 || i == 6);
            chk("eop", cq[i].eop, i == 1 || i == 5 || i == 7);
            chk("len", cq[i].sop ? cq[i].len_dw : 0, cq[i].sop ? 2 + 2 * (i == 2) : 0);
            chk("status", cq[i].status, CPL_SC);
        end
    endtask : t_split
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_sys) #1;
        rst_n = 1'h1;
        cpl_ready = 1'h1;
        t_err(RESP_DECERR, CPL_UR);
        t_err(RESP_SLVERR, CPL_CA);
        t_poison();
        t_zero();
        t_split();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        mismatches++;
        end_of_test();
    end
endmodule : inbound_master_error_handling_test
`default_nettype wire
